// ---- capacity_staging.sv ----
`timescale 1ns/100ps
module capacity_staging #(
    parameter int unsigned TICK_CYCLES = staging_pkg::TICK_CYCLES_DEF,
    parameter int unsigned SEC_PER_DAY = staging_pkg::SEC_PER_DAY_DEF
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // Demand inputs (same clock)
    input wire logic [9:0] pid_demand_i,
    input wire logic [12:0] analog_input_first_i,
    input wire logic [12:0] analog_input_second_i,
    // Direct compressor
    output logic master_run_o,
    output logic [6:0] master_cap_o,
    output logic [12:0] master_rpm_o,
    // Client commands towards the digital_port_second framer
    output logic client_cmd_valid_o,
    output logic [7:0] client_cmd_addr_o,
    output logic [6:0] client_cmd_cap_o
);
    import staging_pkg::*;

    typedef struct packed {
        logic awready, wready, bvalid, arready, rvalid, aw_got, w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
        logic [1:0] count, src;
        logic [7:0] min_stop, min_run;
        logic [5:0] period, swap, stagger;
        logic [6:0] stop_thr, cyc_thr, emerg, min_cap, rmin, rmax;
        logic [12:0] vfall, vmax, vstart, vend;
        logic [31:0] tick_cnt;
        logic [2:0] run;
        comp_mode_t [2:0] mode;
        logic [2:0][15:0] tmr;
        logic [2:0][15:0] pwm;
        logic [2:0][6:0] req;
        logic [2:0][6:0] cap;
        logic [15:0] stag;
        logic [1:0] main;
        logic [31:0] main_rt;
        logic [1:0] cmd_pend;
        logic cmd_valid;
        logic [7:0] cmd_addr;
        logic [6:0] cmd_cap;
        logic [12:0] rpm;
    } state_t;

    state_t s_q, s_d;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] clampw(input logic [31:0] v, input logic [31:0] lo,
                                           input logic [31:0] hi);
        clampw = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampw

    function automatic int phys_of(input logic [1:0] main, input int r, input logic [1:0] cnt);
        phys_of = (r < int'(cnt)) ? (int'(main) + r) % int'(cnt) : r;
    endfunction : phys_of

    function automatic logic [6:0] ramp(input logic [12:0] v, input state_t s);
        int num;
        int c;
        num = int'(v) - int'(s.vstart);
        if (s.vend <= s.vstart) begin
            c = (v >= s.vend) ? int'(s.rmax) : int'(s.rmin);
        end else begin
            c = int'(s.rmin) + ((int'(s.rmax) - int'(s.rmin)) * num)
                / (int'(s.vend) - int'(s.vstart));
        end
        ramp = 7'(clampw(32'(c < 0 ? 0 : c), 32'(0), 32'(PCT_FULL)));
    endfunction : ramp

    function automatic logic [31:0] read_reg(input logic [7:0] a, input state_t s);
        if (a == OFS_COUNT) read_reg = 32'(s.count);
        else if (a == OFS_SRC) read_reg = 32'(s.src);
        else if (a == OFS_MIN_STOP) read_reg = 32'(s.min_stop);
        else if (a == OFS_MIN_RUN) read_reg = 32'(s.min_run);
        else if (a == OFS_PERIOD) read_reg = 32'(s.period);
        else if (a == OFS_SWAP) read_reg = 32'(s.swap);
        else if (a == OFS_STOP_THR) read_reg = 32'(s.stop_thr);
        else if (a == OFS_CYC_THR) read_reg = 32'(s.cyc_thr);
        else if (a == OFS_STAGGER) read_reg = 32'(s.stagger);
        else if (a == OFS_EMERG) read_reg = 32'(s.emerg);
        else if (a == OFS_VFALL) read_reg = 32'(s.vfall);
        else if (a == OFS_VMAX) read_reg = 32'(s.vmax);
        else if (a == OFS_VSTART) read_reg = 32'(s.vstart);
        else if (a == OFS_VEND) read_reg = 32'(s.vend);
        else if (a == OFS_RMIN) read_reg = 32'(s.rmin);
        else if (a == OFS_RMAX) read_reg = 32'(s.rmax);
        else if (a == OFS_MIN_CAP) read_reg = 32'(s.min_cap);
        else if (a == OFS_CAPS) read_reg = {8'h00, 1'b0, s.cap[2], 1'b0, s.cap[1], 1'b0, s.cap[0]};
        else if (a == OFS_MAIN) read_reg = 32'(s.main) + 32'h1;
        else read_reg = 32'h0;
    endfunction : read_reg

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= OFS_MAIN) && (a[1:0] == 2'h0);
    endfunction : mapped

    // ==========================================================
    // Demand
    logic tick;
    logic analog_mode;
    logic [12:0] vin;
    logic analog_bad;
    logic [8:0] total;
    logic [6:0] thr_eff;

    assign tick = (s_q.tick_cnt == 32'(TICK_CYCLES - 1));
    assign analog_mode = (s_q.src != SRC_PID);
    assign vin = (s_q.src == SRC_AIN2) ? analog_input_second_i : analog_input_first_i;
    assign analog_bad = (vin < s_q.vfall) || (vin > s_q.vmax);
    // Total demand scaled to count * 100 percent
    assign total = analog_mode
        ? 9'(ramp(vin, s_q) * s_q.count)
        : 9'((32'(pid_demand_i) * 32'(s_q.count) * PCT_FULL) / PERMILLE_FULL);
    assign thr_eff = (s_q.min_cap > s_q.cyc_thr) ? s_q.min_cap : s_q.cyc_thr;

    // ==========================================================
    // Next state
    always_comb begin
        logic [31:0] merged;
        logic all_cyc;
        logic [1:0] nrun;
        logic started;
        logic want;
        int i;
        logic [6:0] rq;
        logic [31:0] per_s, on_t, off_t;
        merged = '0;
        all_cyc = 1'b0;
        nrun = 2'h0;
        started = 1'b0;
        want = 1'b0;
        i = 0;
        rq = '0;
        per_s = '0;
        on_t = '0;
        off_t = '0;
        s_d = s_q;

        // Bus write side
        if (awvalid_i && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = awaddr_i;
        end
        if (wvalid_i && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = wdata_i;
            s_d.wstrb = wstrb_i;
        end
        if (s_q.bvalid && bready_i) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            merged = read_reg(s_q.awaddr, s_q);
            for (int b = 0; b < 4; b++) begin
                if (s_q.wstrb[b]) merged[b*8 +: 8] = s_q.wdata[b*8 +: 8];
            end
            if (s_q.awaddr == OFS_COUNT) s_d.count = 2'(clampw(merged, 32'(COUNT_DEF), 32'(COUNT_MAX)));
            else if (s_q.awaddr == OFS_SRC) s_d.src = 2'(clampw(merged, 32'(SRC_PID), 32'(SRC_AIN2)));
            else if (s_q.awaddr == OFS_MIN_STOP) s_d.min_stop = 8'(clampw(merged, 32'h1, 32'hf0));
            else if (s_q.awaddr == OFS_MIN_RUN) s_d.min_run = 8'(clampw(merged, 32'h1, 32'hf0));
            else if (s_q.awaddr == OFS_PERIOD) s_d.period = 6'(clampw(merged, 32'(PERIOD_MIN), 32'(LIMIT_60)));
            else if (s_q.awaddr == OFS_SWAP) s_d.swap = 6'(clampw(merged, 32'h0, 32'(LIMIT_60)));
            else if (s_q.awaddr == OFS_STOP_THR) s_d.stop_thr = 7'(clampw(merged, 32'h1, 32'(PCT_FULL)));
            else if (s_q.awaddr == OFS_CYC_THR) s_d.cyc_thr = 7'(clampw(merged, 32'(CYC_THR_MIN), 32'(PCT_FULL)));
            else if (s_q.awaddr == OFS_STAGGER) s_d.stagger = 6'(clampw(merged, 32'h0, 32'(LIMIT_60)));
            else if (s_q.awaddr == OFS_EMERG) s_d.emerg = 7'(clampw(merged, 32'h0, 32'(PCT_FULL)));
            else if (s_q.awaddr == OFS_VFALL) s_d.vfall = merged[12:0];
            else if (s_q.awaddr == OFS_VMAX) s_d.vmax = merged[12:0];
            else if (s_q.awaddr == OFS_VSTART) s_d.vstart = merged[12:0];
            else if (s_q.awaddr == OFS_VEND) s_d.vend = merged[12:0];
            else if (s_q.awaddr == OFS_RMIN) s_d.rmin = 7'(clampw(merged, 32'h0, 32'(PCT_FULL)));
            else if (s_q.awaddr == OFS_RMAX) s_d.rmax = 7'(clampw(merged, 32'h0, 32'(PCT_FULL)));
            else if (s_q.awaddr == OFS_MIN_CAP) s_d.min_cap = 7'(clampw(merged, 32'h0, 32'(PCT_FULL)));
            else s_d.bresp = RESP_SLVERR;
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;

        // Bus read side
        if (s_q.rvalid && rready_i) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid_i && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = read_reg(araddr_i, s_q);
            s_d.rresp = mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end
        s_d.arready = !s_d.rvalid;

        // Client command sequencing
        s_d.cmd_valid = 1'b0;
        if (s_q.cmd_pend[0]) begin
            s_d.cmd_valid = 1'b1;
            s_d.cmd_addr = CLIENT1_ADDR;
            s_d.cmd_cap = s_q.cap[1];
            s_d.cmd_pend[0] = 1'b0;
        end else if (s_q.cmd_pend[1]) begin
            s_d.cmd_valid = 1'b1;
            s_d.cmd_addr = CLIENT2_ADDR;
            s_d.cmd_cap = s_q.cap[2];
            s_d.cmd_pend[1] = 1'b0;
        end

        // Staging, once per tick
        s_d.tick_cnt = tick ? 32'h0 : s_q.tick_cnt + 32'h1;
        if (s_q.main >= s_q.count) begin
            s_d.main = 2'h0;
            s_d.main_rt = 32'h0;
        end else if (tick) begin
            if (s_q.run[s_q.main]) s_d.main_rt = s_q.main_rt + 32'h1;
            if (s_q.swap != 6'h0 && s_q.main_rt > 32'(s_q.swap) * 32'(SEC_PER_DAY)) begin
                s_d.main = 2'((32'(s_q.main) + 32'h1) % 32'(s_q.count));
                s_d.main_rt = 32'h0;
            end
        end
        if (tick) begin
            all_cyc = 32'(total) < 32'(s_q.cyc_thr) * 32'(s_q.count);
            nrun = 2'((32'(total) + PCT_FULL - 1) / PCT_FULL);
            if (nrun == 2'h0) nrun = 2'h1;
            if (s_q.stag != 16'hffff) s_d.stag = s_q.stag + 16'h1;
            per_s = 32'(s_q.period) * SEC_PER_MIN;
            for (int r = 0; r < 3; r++) begin
                i = phys_of(s_q.main, r, s_q.count);
                if (r >= int'(s_q.count)) rq = 7'h0;
                else if (analog_mode && analog_bad) rq = s_q.emerg;
                else if (all_cyc) rq = 7'(total / 9'(s_q.count));
                else if (r < int'(nrun)) rq = 7'(total / 9'(nrun));
                else rq = 7'h0;
                s_d.req[i] = rq;
                if (s_q.tmr[i] != 16'hffff) s_d.tmr[i] = s_q.tmr[i] + 16'h1;
                // On-time in proportion, clipped and period stretched
                on_t = (per_s * 32'(rq)) / 32'(thr_eff);
                if (on_t < 32'(s_q.min_run)) on_t = 32'(s_q.min_run);
                off_t = (per_s > on_t) ? per_s - on_t : 32'h0;
                if (off_t < 32'(s_q.min_stop)) off_t = 32'(s_q.min_stop);
                if (rq < s_q.stop_thr || r >= int'(s_q.count)) begin
                    s_d.mode[i] = M_STOP;
                    s_d.pwm[i] = 16'h0;
                    want = 1'b0;
                end else if (rq < thr_eff) begin
                    s_d.mode[i] = M_CYCLE;
                    s_d.pwm[i] = (32'(s_q.pwm[i]) + 32'h1 >= on_t + off_t) ? 16'h0
                                 : s_q.pwm[i] + 16'h1;
                    want = 32'(s_q.pwm[i]) < on_t;
                end else begin
                    s_d.mode[i] = M_SPEED;
                    s_d.pwm[i] = 16'h0;
                    want = 1'b1;
                end
                if (s_q.run[i] && !want && s_q.tmr[i] >= 16'(s_q.min_run)) begin
                    s_d.run[i] = 1'b0;
                    s_d.tmr[i] = 16'h0;
                end else if (!s_q.run[i] && want && s_q.tmr[i] >= 16'(s_q.min_stop) && !started
                             && (r == 0 || s_q.stag >= 16'(s_q.stagger))) begin
                    s_d.run[i] = 1'b1;
                    s_d.tmr[i] = 16'h0;
                    // The start tick counts as the first second of the stagger delay
                    s_d.stag = 16'h1;
                    started = 1'b1;
                end
                if (!s_d.run[i]) s_d.cap[i] = 7'h0;
                else if (s_d.mode[i] == M_SPEED) s_d.cap[i] = rq;
                else s_d.cap[i] = thr_eff;
            end
            s_d.cmd_pend = {s_q.count == COUNT_MAX, s_q.count >= 2'h2};
        end
        s_d.rpm = 13'((32'(s_d.cap[0]) * RPM_MAX) / PCT_FULL);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
            s_q.count <= COUNT_DEF;
            s_q.src <= SRC_PID;
            s_q.min_stop <= MIN_STOP_DEF;
            s_q.min_run <= MIN_RUN_DEF;
            s_q.period <= PERIOD_DEF;
            s_q.swap <= SWAP_DEF;
            s_q.stagger <= STAGGER_DEF;
            s_q.stop_thr <= STOP_THR_DEF;
            s_q.cyc_thr <= CYC_THR_DEF;
            s_q.emerg <= EMERG_DEF;
            s_q.min_cap <= MIN_CAP_DEF;
            s_q.rmin <= RMIN_DEF;
            s_q.rmax <= RMAX_DEF;
            s_q.vfall <= VFALL_DEF;
            s_q.vmax <= VMAX_DEF;
            s_q.vstart <= VSTART_DEF;
            s_q.vend <= VEND_DEF;
            s_q.mode <= '{M_STOP, M_STOP, M_STOP};
            s_q.tmr <= {3{16'hffff}};
            s_q.stag <= 16'hffff;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign awready_o = s_q.awready;
    assign wready_o = s_q.wready;
    assign bvalid_o = s_q.bvalid;
    assign bresp_o = s_q.bresp;
    assign arready_o = s_q.arready;
    assign rvalid_o = s_q.rvalid;
    assign rdata_o = s_q.rdata;
    assign rresp_o = s_q.rresp;
    assign master_run_o = s_q.run[0];
    assign master_cap_o = s_q.cap[0];
    assign master_rpm_o = s_q.rpm;
    assign client_cmd_valid_o = s_q.cmd_valid;
    assign client_cmd_addr_o = s_q.cmd_addr;
    assign client_cmd_cap_o = s_q.cmd_cap;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_start_one;
        $rose(s_q.run[1]) && s_q.main != 2'h1;
    endsequence

    a_count_range: assert property (s_q.count >= COUNT_DEF && s_q.count <= COUNT_MAX)
        else $error("compressor count out of range");
    a_min_run_held: assert property ($fell(s_q.run[0]) |-> $past(s_q.tmr[0]) >= 16'($past(s_q.min_run)))
        else $error("compressor stopped before min run time");
    a_min_stop_held: assert property ($rose(s_q.run[0]) |-> $past(s_q.tmr[0]) >= 16'($past(s_q.min_stop)))
        else $error("compressor started before min stop time");
    a_one_start: assert property (!($rose(s_q.run[0]) && $rose(s_q.run[1])) && !($rose(s_q.run[1]) && $rose(s_q.run[2])))
        else $error("two compressors started together");
    a_stagger_gap: assert property (s_start_one |-> $past(s_q.stag) >= 16'($past(s_q.stagger)))
        else $error("stagger delay not honoured");
    a_low_total: assert property (tick && 32'(total) < 32'(s_q.cyc_thr) * 32'(s_q.count) && !(analog_mode && analog_bad) |=> s_q.mode[0] != M_SPEED)
        else $error("speed mode under low total demand");
    a_stop_low: assert property (tick && s_q.count == COUNT_DEF && !analog_mode && 7'(total) < s_q.stop_thr |=> s_q.mode[0] == M_STOP)
        else $error("compressor not stopped below threshold");
    a_emergency: assert property (tick && analog_mode && analog_bad |=> s_q.req[s_q.main] == s_q.emerg)
        else $error("emergency capacity not applied");
    a_swap_cause: assert property ($changed(s_q.main) && $past(s_q.main) < $past(s_q.count) |-> $past(s_q.swap) != 6'h0)
        else $error("main swapped with swap time zero");
    a_client_cmd: assert property (tick && s_q.count == COUNT_MAX |-> ##2 client_cmd_valid_o && client_cmd_addr_o == CLIENT1_ADDR ##1 client_cmd_valid_o && client_cmd_addr_o == CLIENT2_ADDR)
        else $error("client commands not sent in order");
    a_cap_off: assert property (!s_q.run[0] |-> master_cap_o == 7'h0)
        else $error("capacity shown for stopped compressor");
endmodule : capacity_staging

// ---- client_model.sv ----
`timescale 1ns/100ps
module client_model (
    // Commands
    input wire logic clk_sys_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [6:0] cmd_cap_i,
    // Client state
    output logic [6:0] cap_o [2],
    output longint start_o [2]
);
    always @(posedge clk_sys_i) begin
        if (cmd_valid_i && cmd_addr_i inside {8'h01, 8'h02}) begin
            cap_o[cmd_addr_i[1]] <= cmd_cap_i;
            if (start_o[cmd_addr_i[1]] == 0 && cmd_cap_i != 7'h00)
                start_o[cmd_addr_i[1]] <= $time;
        end
    end
endmodule : client_model

// ---- staging_pkg.sv ----
// Operation
// - Mode picks PID or analog input demand
// - One to three compressors, default one
// - Full scale is count times 100 percent
// - Defaults from 2000-4500 rpm, 100 percent top
// - Below stop threshold the compressor stops
// - Below cycling threshold compressor cycles on/off
// - Low total keeps all at threshold or less
// - Swap main after runtime exceeds swap days
// - Start one at a time, stagger delay
// - Period time sets on/off cycle length
// - Period lengthens to honour min times
// - Minimum stop and run times per compressor
// - Internal mode uses PID cooling demand
// - Voltage out of band gives emergency capacity
// - Linear ramp from voltage to capacity
// - Clients commanded at addresses 1 and 2
// - Directly driven compressor is main by default
// - Read-only capacities and current main index
package staging_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_S;
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned SEC_PER_DAY_DEF = 86_400;
    // ==========================================================
    // Capacity scaling
    localparam int unsigned PCT_FULL = 100;
    localparam int unsigned PERMILLE_FULL = 1000;
    localparam int unsigned RPM_MIN = 2000;
    localparam int unsigned RPM_MAX = 4500;
    localparam logic [6:0] MIN_CAP_DEF = 7'((RPM_MIN * PCT_FULL + RPM_MAX - 1) / RPM_MAX);
    localparam logic [7:0] CLIENT1_ADDR = 8'h01;
    localparam logic [7:0] CLIENT2_ADDR = 8'h02;
    // ==========================================================
    // Demand sources
    localparam logic [1:0] SRC_PID = 2'h0;
    localparam logic [1:0] SRC_AIN1 = 2'h1;
    localparam logic [1:0] SRC_AIN2 = 2'h2;
    // ==========================================================
    // Defaults and limits (times in s, min, day; voltages in mV)
    localparam logic [1:0] COUNT_DEF = 2'h1;
    localparam logic [1:0] COUNT_MAX = 2'h3;
    localparam logic [7:0] MIN_STOP_DEF = 8'h5a;
    localparam logic [7:0] MIN_RUN_DEF = 8'h1e;
    localparam logic [5:0] PERIOD_DEF = 6'h1e;
    localparam logic [5:0] PERIOD_MIN = 6'h05;
    localparam logic [5:0] LIMIT_60 = 6'h3c;
    localparam logic [5:0] SWAP_DEF = 6'h01;
    localparam logic [5:0] STAGGER_DEF = 6'h05;
    localparam logic [6:0] STOP_THR_DEF = 7'h01;
    localparam logic [6:0] CYC_THR_DEF = 7'h2d;
    localparam logic [6:0] CYC_THR_MIN = 7'h14;
    localparam logic [6:0] EMERG_DEF = 7'h64;
    localparam logic [6:0] RMIN_DEF = 7'h00;
    localparam logic [6:0] RMAX_DEF = 7'h64;
    localparam logic [12:0] VFALL_DEF = 13'h012c;
    localparam logic [12:0] VMAX_DEF = 13'h157c;
    localparam logic [12:0] VSTART_DEF = 13'h03e8;
    localparam logic [12:0] VEND_DEF = 13'h1388;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_SRC = 8'h04;
    localparam logic [7:0] OFS_MIN_STOP = 8'h08;
    localparam logic [7:0] OFS_MIN_RUN = 8'h0c;
    localparam logic [7:0] OFS_PERIOD = 8'h10;
    localparam logic [7:0] OFS_SWAP = 8'h14;
    localparam logic [7:0] OFS_STOP_THR = 8'h18;
    localparam logic [7:0] OFS_CYC_THR = 8'h1c;
    localparam logic [7:0] OFS_STAGGER = 8'h20;
    localparam logic [7:0] OFS_EMERG = 8'h24;
    localparam logic [7:0] OFS_VFALL = 8'h28;
    localparam logic [7:0] OFS_VMAX = 8'h2c;
    localparam logic [7:0] OFS_VSTART = 8'h30;
    localparam logic [7:0] OFS_VEND = 8'h34;
    localparam logic [7:0] OFS_RMIN = 8'h38;
    localparam logic [7:0] OFS_RMAX = 8'h3c;
    localparam logic [7:0] OFS_MIN_CAP = 8'h40;
    localparam logic [7:0] OFS_CAPS = 8'h44;
    localparam logic [7:0] OFS_MAIN = 8'h48;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        M_STOP = 3'b001,
        M_CYCLE = 3'b010,
        M_SPEED = 3'b100
    } comp_mode_t;
endpackage : staging_pkg

// ---- tb_multi_compressor_capacity_staging.sv ----
`timescale 1ns/100ps
module tb_multi_compressor_capacity_staging;
    import staging_pkg::*;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, awvalid_i = 1'b0, wvalid_i = 1'b0;
    logic bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0, awready_o, wready_o;
    logic bvalid_o, arready_o, rvalid_o, master_run_o, client_cmd_valid_o;
    logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00, client_cmd_addr_o;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [12:0] analog_input_first_i = 13'h0, analog_input_second_i = 13'h0, master_rpm_o;
    logic [9:0] pid_demand_i = 10'h0;
    logic [6:0] master_cap_o, client_cmd_cap_o, cap [2];
    logic [3:0] wstrb_i = 4'hf;
    logic [1:0] bresp_o, rresp_o;
    longint start [2];
    int errors = 0, checks = 0;
    localparam int TICK = 10;
    capacity_staging #(.TICK_CYCLES(TICK)) DUT (.*);
    client_model far_end (.clk_sys_i, .cmd_valid_i(client_cmd_valid_o),
        .cmd_addr_i(client_cmd_addr_o), .cmd_cap_i(client_cmd_cap_o), .cap_o(cap), .start_o(start));
    initial forever #25 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        @(posedge clk_sys_i);
        {awaddr_i, araddr_i, wdata_i} <= {a, a, v};
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} <= {w, w, w, !w, !w};
        do @(negedge clk_sys_i); while (!(w ? awready_o && wready_o : arready_o));
        @(posedge clk_sys_i);
        {awvalid_i, wvalid_i, arvalid_i} <= 3'h0;
        do @(negedge clk_sys_i); while (!(w ? bvalid_o : rvalid_o));
        chk("resp", 32'(e), 32'(w ? bresp_o : rresp_o));
        if (!w) chk("rdata", v, rdata_o);
        @(posedge clk_sys_i);
        {bready_i, rready_i} <= 2'h0;
    endtask : acc
    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic t_regs;
        logic [7:0] a [7] = '{OFS_COUNT, OFS_SRC, OFS_CYC_THR, OFS_STAGGER, OFS_PERIOD,
            OFS_MIN_STOP, OFS_MIN_RUN};
        logic [31:0] e [7] = '{1, 0, 45, 5, 30, 90, 30};
        foreach (a[i]) acc(1'b0, a[i], e[i], RESP_OKAY);
        acc(1'b0, 8'h80, 32'h0, RESP_SLVERR);
        acc(1'b1, OFS_CAPS, 32'h0, RESP_SLVERR);
        $display("regs done");
    endtask : t_regs
    task automatic t_multi;
        acc(1'b1, OFS_COUNT, 32'h3, RESP_OKAY);
        pid_demand_i <= 10'd1000;
        repeat (200) @(posedge clk_sys_i);
        chk("client1", 32'd100, 32'(cap[0]));
        chk("client2", 32'd100, 32'(cap[1]));
        chk("stagger", 32'h1, 32'(start[1] - start[0] >= 50 * TICK * int'(STAGGER_DEF)
            && start[1] - start[0] < 50 * TICK * (int'(STAGGER_DEF) + 1)));
        acc(1'b0, OFS_CAPS, 32'h646464, RESP_OKAY);
        chk("rpm", 32'd4500, 32'(master_rpm_o));
        acc(1'b0, OFS_MAIN, 32'h1, RESP_OKAY);
        $display("multi done");
    endtask : t_multi
    task automatic t_analog;
        acc(1'b1, OFS_COUNT, 32'h1, RESP_OKAY);
        acc(1'b1, OFS_EMERG, 32'd70, RESP_OKAY);
        acc(1'b1, OFS_SRC, 32'h1, RESP_OKAY);
        analog_input_first_i <= 13'd3000;
        repeat (50) @(posedge clk_sys_i);
        chk("ramp", 32'd50, 32'(master_cap_o));
        analog_input_first_i <= 13'd100;
        repeat (30) @(posedge clk_sys_i);
        chk("emergency", 32'd70, 32'(master_cap_o));
        analog_input_second_i <= 13'd3000;
        acc(1'b1, OFS_SRC, 32'(SRC_AIN2), RESP_OKAY);
        repeat (30) @(posedge clk_sys_i);
        chk("ramp2", 32'd50, 32'(master_cap_o));
        $display("analog done");
    endtask : t_analog
    task automatic t_cycle;
        int n;
        int per;
        n = 0;
        per = int'(PERIOD_MIN) * int'(SEC_PER_MIN);
        acc(1'b1, OFS_PERIOD, 32'(PERIOD_MIN), RESP_OKAY);
        acc(1'b1, OFS_MIN_RUN, 32'h1, RESP_OKAY);
        acc(1'b1, OFS_MIN_STOP, 32'h1, RESP_OKAY);
        pid_demand_i <= 10'd200;
        acc(1'b1, OFS_SRC, 32'(SRC_PID), RESP_OKAY);
        repeat (30) @(posedge clk_sys_i);
        chk("cycle_cap", 32'(CYC_THR_DEF), 32'(master_cap_o));
        chk("cycle_run", 32'h1, 32'(master_run_o));
        while (master_run_o && n < 2000) begin
            @(posedge clk_sys_i);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (!master_run_o && n < 3000);
        chk("off_time", 32'(TICK * (per - per * 20 / int'(CYC_THR_DEF))), 32'(n));
        $display("cycle done");
    endtask : t_cycle
    initial begin
        repeat (4) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_regs();
        t_multi();
        t_analog();
        t_cycle();
        final_report();
    end
    initial begin
        repeat (9000) @(posedge clk_sys_i);
        errors++;
        final_report();
    end
endmodule : tb_multi_compressor_capacity_staging
